// ==== dcc_pkg.sv ====
// package: register map, field positions and reset values of the dual counter capture block
package dcc_pkg;
  // register indices (printed offsets are not all multiples of four)
  localparam logic [3:0] IDX_NARROW_CTRL = 4'h0;
  localparam logic [3:0] IDX_COMMON_CTRL = 4'h1;
  localparam logic [3:0] IDX_WIDE_CTRL = 4'h2;
  localparam logic [3:0] IDX_NARROW_INIT = 4'h3;
  localparam logic [3:0] IDX_WIDE_INIT_LO = 4'h4;
  localparam logic [3:0] IDX_IRQ_STATUS = 4'h5;
  localparam logic [3:0] IDX_IRQ_MASK = 4'h6;
  localparam logic [3:0] IDX_WIDE_HOLD = 4'h7;
  localparam logic [3:0] IDX_WIDE_CAP_LO = 4'h8;
  localparam logic [3:0] IDX_WIDE_CAP_HI = 4'h9;
  localparam logic [3:0] IDX_NARROW_CAP_LO = 4'hA;
  localparam logic [3:0] IDX_NARROW_CAP_HI = 4'hB;
  // common control fields
  localparam int CC_MODE = 7;
  localparam int CC_PIN = 6;
  localparam int CC_LOGIC_HI = 5;
  localparam int CC_LOGIC_LO = 4;
  // wide control fields
  localparam int WC_RUN = 7;
  localparam int WC_SINGLE = 6;
  localparam int WC_TIMEOUT = 5;
  localparam int WC_PRE_HI = 4;
  localparam int WC_PRE_LO = 3;
  localparam int WC_CAP_MASK = 2;
  localparam int WC_CNT_MASK = 1;
  localparam int WC_ROUTE = 0;
  // narrow control fields
  localparam int NC_RUN = 7;
  localparam int NC_ROUTE = 0;
  // interrupt status/mask bits
  localparam int IRQ_NCAP = 0;
  localparam int IRQ_NTMO = 1;
  localparam int IRQ_WCAP = 2;
  localparam int IRQ_WTMO = 3;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] NARROW_RELOAD = 8'hFF;
  // edge select codes in demodulation mode
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  // counter state carried together
  typedef struct packed {
    logic [7:0] narrow;
    logic [15:0] wide;
  } dcc_count_t;
endpackage

// ==== dcc_top.sv ====
// dual counter capture block: apb registers, two counters, edge capture and interrupts
`timescale 1ns/10ps
module dcc_top (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic demod_in_a, // demodulator input, pin select 0
  input wire logic demod_in_b, // demodulator input, pin select 1
  input wire logic narrow_port_value, // ordinary port value for narrow pin
  input wire logic wide_port_value, // ordinary port value for wide pin
  input wire logic combined_port_value, // ordinary port value for combined pin
  output logic narrow_output_pin, // narrow pin level
  output logic wide_output_pin, // wide pin level
  output logic combined_output_pin, // combined pin level
  output logic irq // level interrupt
);
  logic [7:0] narrow_ctrl_q, common_ctrl_q, wide_ctrl_q, narrow_init_q, wide_init_lo_q;
  logic [7:0] wide_reload_upper_hold_q, irq_mask_q, irq_status_q;
  logic [7:0] ncap_lo_q, ncap_hi_q, wcap_lo_q, wcap_hi_q;
  logic wide_timeout_q, narrow_tog_q, wide_tog_q;
  dcc_pkg::dcc_count_t cnt_q;
  logic [2:0] pre_q;
  logic [1:0] ina_q, inb_q;
  logic in_prev_q;
  logic [3:0] idx;
  logic mapped, wr_en, rd_en;
  logic demod_in, demod_mode, rise, fall, edge_hit;
  logic narrow_tmo, wide_tmo, wide_tick, wide_edge, wide_run;
  logic [1:0] edge_sel, psel_code;
  logic [3:0] events;

  // apb decode: word aligned, index = byte address / 4
  assign idx = paddr[5:2];
  assign mapped = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0) && (idx <= dcc_pkg::IDX_NARROW_CAP_HI);
  assign wr_en = psel && penable && pwrite && mapped;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // input pins pass two flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ina_q <= 2'h0;
      inb_q <= 2'h0;
    end else begin
      ina_q <= {ina_q[0], demod_in_a};
      inb_q <= {inb_q[0], demod_in_b};
    end
  end

  // demodulator input and edge detection
  assign demod_mode = common_ctrl_q[dcc_pkg::CC_MODE];
  assign demod_in = common_ctrl_q[dcc_pkg::CC_PIN] ? inb_q[1] : ina_q[1];
  assign edge_sel = common_ctrl_q[dcc_pkg::CC_LOGIC_HI:dcc_pkg::CC_LOGIC_LO];
  assign rise = demod_in && !in_prev_q;
  assign fall = !demod_in && in_prev_q;
  always_comb begin
    case (edge_sel)
      dcc_pkg::EDGE_FALL: edge_hit = fall;
      dcc_pkg::EDGE_RISE: edge_hit = rise;
      dcc_pkg::EDGE_BOTH: edge_hit = rise || fall;
      default: edge_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_prev_q <= 1'b0;
    end else begin
      in_prev_q <= demod_in;
    end
  end

  // control registers written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      narrow_ctrl_q <= dcc_pkg::RST_BYTE;
      common_ctrl_q <= dcc_pkg::RST_BYTE;
      wide_ctrl_q <= dcc_pkg::RST_BYTE;
      narrow_init_q <= dcc_pkg::NARROW_RELOAD;
      wide_init_lo_q <= dcc_pkg::RST_BYTE;
      wide_reload_upper_hold_q <= dcc_pkg::RST_BYTE;
      irq_mask_q <= dcc_pkg::RST_BYTE;
    end else if (wr_en) begin
      case (idx)
        dcc_pkg::IDX_NARROW_CTRL: narrow_ctrl_q <= pwdata[7:0];
        dcc_pkg::IDX_COMMON_CTRL: common_ctrl_q <= pwdata[7:0];
        dcc_pkg::IDX_WIDE_CTRL: wide_ctrl_q <= pwdata[7:0];
        dcc_pkg::IDX_NARROW_INIT: narrow_init_q <= pwdata[7:0];
        dcc_pkg::IDX_WIDE_INIT_LO: wide_init_lo_q <= pwdata[7:0];
        dcc_pkg::IDX_WIDE_HOLD: wide_reload_upper_hold_q <= pwdata[7:0];
        dcc_pkg::IDX_IRQ_MASK: irq_mask_q <= pwdata[7:0];
        default: ; // capture registers ignore writes
      endcase
    end
  end

  // wide prescaler: enable pulse every 1,2,4,8 cycles
  assign psel_code = wide_ctrl_q[dcc_pkg::WC_PRE_HI:dcc_pkg::WC_PRE_LO];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 3'h0;
    end else begin
      pre_q <= pre_q + 3'h1;
    end
  end
  always_comb begin
    case (psel_code)
      2'h0: wide_tick = 1'b1;
      2'h1: wide_tick = (pre_q[0] == 1'b1);
      2'h2: wide_tick = (pre_q[1:0] == 2'h3);
      default: wide_tick = (pre_q == 3'h7);
    endcase
  end

  // narrow counter: reloads from init outside demodulation, from FF in demodulation, edge captures
  assign wide_run = wide_ctrl_q[dcc_pkg::WC_RUN];
  assign narrow_tmo = narrow_ctrl_q[dcc_pkg::NC_RUN] && !(demod_mode && edge_hit) && (cnt_q.narrow == 8'h00);
  assign wide_edge = demod_mode && edge_hit && !wide_ctrl_q[dcc_pkg::WC_SINGLE];
  assign wide_tmo = wide_run && wide_tick && !wide_edge && (cnt_q.wide == 16'h0000);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q.narrow <= dcc_pkg::NARROW_RELOAD;
      narrow_tog_q <= 1'b0;
    end else if (narrow_ctrl_q[dcc_pkg::NC_RUN]) begin
      if (demod_mode && edge_hit) begin
        cnt_q.narrow <= dcc_pkg::NARROW_RELOAD;
      end else if (cnt_q.narrow == 8'h00) begin
        cnt_q.narrow <= demod_mode ? dcc_pkg::NARROW_RELOAD : narrow_init_q;
        narrow_tog_q <= ~narrow_tog_q;
      end else begin
        cnt_q.narrow <= cnt_q.narrow - 8'h01;
      end
    end
  end

  // wide counter: reload from hold and low init
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q.wide <= 16'hFFFF;
      wide_tog_q <= 1'b0;
    end else if (wide_edge) begin
      cnt_q.wide <= {wide_reload_upper_hold_q, wide_init_lo_q};
    end else if (wide_run && wide_tick) begin
      if (cnt_q.wide == 16'h0000) begin
        cnt_q.wide <= {wide_reload_upper_hold_q, wide_init_lo_q};
        wide_tog_q <= ~wide_tog_q;
      end else begin
        cnt_q.wide <= cnt_q.wide - 16'h0001;
      end
    end
  end

  // capture registers: narrow by level, wide by byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ncap_hi_q <= dcc_pkg::RST_BYTE;
      ncap_lo_q <= dcc_pkg::RST_BYTE;
      wcap_hi_q <= dcc_pkg::RST_BYTE;
      wcap_lo_q <= dcc_pkg::RST_BYTE;
    end else if (demod_mode && edge_hit) begin
      if (fall) begin
        ncap_hi_q <= ~cnt_q.narrow; // counts elapsed while high
      end else begin
        ncap_lo_q <= ~cnt_q.narrow; // counts elapsed while low
      end
      if (wide_edge) begin
        wcap_hi_q <= cnt_q.wide[15:8];
        wcap_lo_q <= cnt_q.wide[7:0];
      end
    end
  end

  // sticky status: set wins over write-one clear
  assign events[dcc_pkg::IRQ_NCAP] = demod_mode && edge_hit && narrow_ctrl_q[dcc_pkg::NC_RUN];
  assign events[dcc_pkg::IRQ_NTMO] = narrow_tmo;
  assign events[dcc_pkg::IRQ_WCAP] = wide_edge;
  assign events[dcc_pkg::IRQ_WTMO] = wide_tmo;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= dcc_pkg::RST_BYTE;
    end else begin
      irq_status_q <= ((wr_en && idx == dcc_pkg::IDX_IRQ_STATUS) ? irq_status_q & ~pwdata[7:0] : irq_status_q)
        | {4'h0, events};
    end
  end

  // wide timeout flag in its control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wide_timeout_q <= 1'b0;
    end else if (wide_tmo) begin
      wide_timeout_q <= 1'b1;
    end else if (wr_en && idx == dcc_pkg::IDX_WIDE_CTRL && pwdata[dcc_pkg::WC_TIMEOUT]) begin
      wide_timeout_q <= 1'b0;
    end
  end

  // interrupt: narrow capture via wide control mask, narrow timeout via counter mask
  assign irq = (irq_status_q[dcc_pkg::IRQ_NCAP] && irq_mask_q[dcc_pkg::IRQ_NCAP]
                && wide_ctrl_q[dcc_pkg::WC_CAP_MASK])
    || (irq_status_q[dcc_pkg::IRQ_NTMO] && irq_mask_q[dcc_pkg::IRQ_NTMO]
        && wide_ctrl_q[dcc_pkg::WC_CNT_MASK])
    || (irq_status_q[dcc_pkg::IRQ_WCAP] && irq_mask_q[dcc_pkg::IRQ_WCAP])
    || (irq_status_q[dcc_pkg::IRQ_WTMO] && irq_mask_q[dcc_pkg::IRQ_WTMO]);

  // pin routing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      narrow_output_pin <= 1'b0;
      wide_output_pin <= 1'b0;
      combined_output_pin <= 1'b0;
    end else begin
      narrow_output_pin <= narrow_ctrl_q[dcc_pkg::NC_ROUTE] ? narrow_tog_q : narrow_port_value;
      wide_output_pin <= wide_ctrl_q[dcc_pkg::WC_ROUTE] ? wide_tog_q : wide_port_value;
      combined_output_pin <= (!demod_mode && common_ctrl_q[dcc_pkg::CC_PIN])
        ? (narrow_tog_q & wide_tog_q) : combined_port_value;
    end
  end

  // read mux; zero-latency apb read
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en && mapped) begin
      case (idx)
        dcc_pkg::IDX_NARROW_CTRL: prdata[7:0] = narrow_ctrl_q;
        dcc_pkg::IDX_COMMON_CTRL: prdata[7:0] = common_ctrl_q;
        dcc_pkg::IDX_WIDE_CTRL: prdata[7:0] = {wide_ctrl_q[7:6], wide_timeout_q, wide_ctrl_q[4:0]};
        dcc_pkg::IDX_NARROW_INIT: prdata[7:0] = narrow_init_q;
        dcc_pkg::IDX_WIDE_INIT_LO: prdata[7:0] = wide_init_lo_q;
        dcc_pkg::IDX_IRQ_STATUS: prdata[7:0] = irq_status_q;
        dcc_pkg::IDX_IRQ_MASK: prdata[7:0] = irq_mask_q;
        dcc_pkg::IDX_WIDE_HOLD: prdata[7:0] = wide_reload_upper_hold_q;
        dcc_pkg::IDX_WIDE_CAP_LO: prdata[7:0] = wcap_lo_q;
        dcc_pkg::IDX_WIDE_CAP_HI: prdata[7:0] = wcap_hi_q;
        dcc_pkg::IDX_NARROW_CAP_LO: prdata[7:0] = ncap_lo_q;
        dcc_pkg::IDX_NARROW_CAP_HI: prdata[7:0] = ncap_hi_q;
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  a_cap_wr_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && idx == dcc_pkg::IDX_NARROW_CAP_HI && !(demod_mode && edge_hit)) |=> $stable(ncap_hi_q))
    else $error("capture register changed by write");
  a_hold_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && idx == dcc_pkg::IDX_WIDE_HOLD) |=> wide_reload_upper_hold_q == $past(pwdata[7:0]))
    else $error("hold byte not written");
  a_wide_cap_hi: assert property (@(posedge pclk) disable iff (!presetn)
    wide_edge |=> wcap_hi_q == $past(cnt_q.wide[15:8]))
    else $error("wide capture high byte wrong");
  a_wide_cap_lo: assert property (@(posedge pclk) disable iff (!presetn)
    wide_edge |=> wcap_lo_q == $past(cnt_q.wide[7:0]))
    else $error("wide capture low byte wrong");
  a_narrow_cap_hi: assert property (@(posedge pclk) disable iff (!presetn)
    (demod_mode && edge_hit && fall) |=> ncap_hi_q == ~$past(cnt_q.narrow))
    else $error("high level capture wrong");
  a_narrow_cap_lo: assert property (@(posedge pclk) disable iff (!presetn)
    (demod_mode && edge_hit && rise) |=> ncap_lo_q == ~$past(cnt_q.narrow))
    else $error("low level capture wrong");
  a_edge_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    wide_ctrl_q[dcc_pkg::WC_SINGLE] |-> !wide_edge)
    else $error("wide counter took edge while ignoring");
  a_timeout_flag: assert property (@(posedge pclk) disable iff (!presetn)
    wide_tmo |=> wide_timeout_q ##1 (wide_timeout_q || $past(wr_en)))
    else $error("wide timeout flag not held");
  a_tmo_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (!wide_ctrl_q[dcc_pkg::WC_CNT_MASK] && !irq_mask_q[dcc_pkg::IRQ_NCAP] && !irq_mask_q[dcc_pkg::IRQ_WCAP]
     && !irq_mask_q[dcc_pkg::IRQ_WTMO]) |-> !irq)
    else $error("timeout interrupt while masked");
  a_cap_irq: assert property (@(posedge pclk) disable iff (!presetn)
    (events[dcc_pkg::IRQ_NCAP] && wide_ctrl_q[dcc_pkg::WC_CAP_MASK] && irq_mask_q[dcc_pkg::IRQ_NCAP]
     && !(wr_en && (idx == dcc_pkg::IDX_WIDE_CTRL || idx == dcc_pkg::IDX_IRQ_MASK))) |=> irq)
    else $error("capture interrupt missing");
  a_prescale_div8: assert property (@(posedge pclk) disable iff (!presetn)
    (psel_code == 2'h3 && wide_tick) |=> (!wide_tick || psel_code != 2'h3) [*7])
    else $error("divide by eight wrong");

  // low level capture keeps its value on writes
  a_ncap_lo_wr_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && idx == dcc_pkg::IDX_NARROW_CAP_LO && !(demod_mode && edge_hit)) |=> $stable(ncap_lo_q))
    else $error("low level capture changed by write");

  // wide capture high byte keeps its value on writes
  a_wcap_hi_wr_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && idx == dcc_pkg::IDX_WIDE_CAP_HI && !wide_edge) |=> $stable(wcap_hi_q))
    else $error("wide capture high byte changed by write");

  // wide capture low byte keeps its value on writes
  a_wcap_lo_wr_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && idx == dcc_pkg::IDX_WIDE_CAP_LO && !wide_edge) |=> $stable(wcap_lo_q))
    else $error("wide capture low byte changed by write");

  // common control takes the written byte
  a_common_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && idx == dcc_pkg::IDX_COMMON_CTRL) |=> common_ctrl_q == $past(pwdata[7:0]))
    else $error("common control not written");

  // hold byte reads back during the access cycle
  a_hold_readback: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && mapped && idx == dcc_pkg::IDX_WIDE_HOLD) |-> prdata[7:0] == wide_reload_upper_hold_q)
    else $error("hold byte read back wrong");

  // write one clears the timeout flag when no timeout competes
  a_tmo_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && idx == dcc_pkg::IDX_WIDE_CTRL && pwdata[dcc_pkg::WC_TIMEOUT] && !wide_tmo) |=> !wide_timeout_q)
    else $error("timeout flag not cleared");

  // without a write of one the timeout flag stays set
  a_tmo_flag_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (wide_timeout_q && !(wr_en && idx == dcc_pkg::IDX_WIDE_CTRL && pwdata[dcc_pkg::WC_TIMEOUT])) |=> wide_timeout_q)
    else $error("timeout flag lost");

  // narrow pin shows the counter output when routed
  a_narrow_route_cnt: assert property (@(posedge pclk) disable iff (!presetn)
    narrow_ctrl_q[dcc_pkg::NC_ROUTE] |=> narrow_output_pin == $past(narrow_tog_q))
    else $error("narrow pin not counter output");

  // narrow pin shows the port value otherwise
  a_narrow_route_port: assert property (@(posedge pclk) disable iff (!presetn)
    !narrow_ctrl_q[dcc_pkg::NC_ROUTE] |=> narrow_output_pin == $past(narrow_port_value))
    else $error("narrow pin not port value");

  // wide pin shows the counter output when routed
  a_wide_route_cnt: assert property (@(posedge pclk) disable iff (!presetn)
    wide_ctrl_q[dcc_pkg::WC_ROUTE] |=> wide_output_pin == $past(wide_tog_q))
    else $error("wide pin not counter output");

  // wide pin shows the port value otherwise
  a_wide_route_port: assert property (@(posedge pclk) disable iff (!presetn)
    !wide_ctrl_q[dcc_pkg::WC_ROUTE] |=> wide_output_pin == $past(wide_port_value))
    else $error("wide pin not port value");

  // capture mask clear keeps the narrow capture interrupt off
  a_cap_mask_off: assert property (@(posedge pclk) disable iff (!presetn)
    (!wide_ctrl_q[dcc_pkg::WC_CAP_MASK] && irq_mask_q[3:1] == 3'h0) |-> !irq)
    else $error("capture interrupt while disabled");

  // divide by one ticks every cycle
  a_div1_tick: assert property (@(posedge pclk) disable iff (!presetn)
    (psel_code == 2'h0) |-> wide_tick)
    else $error("divide by one wrong");

  // divide by two ticks every other cycle
  a_div2_tick: assert property (@(posedge pclk) disable iff (!presetn)
    (psel_code == 2'h1 && wide_tick) |=> (!wide_tick || psel_code != 2'h1))
    else $error("divide by two wrong");

  // divide by four leaves three idle cycles
  a_div4_tick: assert property (@(posedge pclk) disable iff (!presetn)
    (psel_code == 2'h2 && wide_tick) |=> (!wide_tick || psel_code != 2'h2) [*3])
    else $error("divide by four wrong");

  // narrow timeout always lands in the status register
  a_narrow_tmo_status: assert property (@(posedge pclk) disable iff (!presetn)
    narrow_tmo |=> irq_status_q[dcc_pkg::IRQ_NTMO])
    else $error("narrow timeout not recorded");
endmodule

// ==== dcc_top_test.sv ====
// self-checking testbench for the dual counter capture block
`timescale 1ns/10ps
module dcc_top_test;
  logic pclk, presetn, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, demod_in_a, demod_in_b, irq;
  logic narrow_port_value, wide_port_value, combined_port_value;
  logic narrow_output_pin, wide_output_pin, combined_output_pin;
  int err_total = 0;
  int check_count = 0;
  int h_len, l_len, n;
  logic [31:0] rd_d;
  logic rd_e;
  logic [7:0] v, hi;
  // byte addresses built from the register indices
  localparam logic [7:0] A_NARROW = {2'b00, dcc_pkg::IDX_NARROW_CTRL, 2'b00};
  localparam logic [7:0] A_COMMON = {2'b00, dcc_pkg::IDX_COMMON_CTRL, 2'b00};
  localparam logic [7:0] A_WIDE = {2'b00, dcc_pkg::IDX_WIDE_CTRL, 2'b00};
  localparam logic [7:0] A_STAT = {2'b00, dcc_pkg::IDX_IRQ_STATUS, 2'b00};
  localparam logic [7:0] A_MASK = {2'b00, dcc_pkg::IDX_IRQ_MASK, 2'b00};
  localparam logic [7:0] A_HOLD = {2'b00, dcc_pkg::IDX_WIDE_HOLD, 2'b00};

  dcc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .demod_in_a(demod_in_a), .demod_in_b(demod_in_b), .narrow_port_value(narrow_port_value),
    .wide_port_value(wide_port_value), .combined_port_value(combined_port_value),
    .narrow_output_pin(narrow_output_pin), .wide_output_pin(wide_output_pin),
    .combined_output_pin(combined_output_pin), .irq(irq));

  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // verdict and end of run
  task automatic end_sim;
    if (err_total == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // exact value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // captured count compare, one count of slack for edge alignment
  task automatic chk_near(input logic [7:0] got, input int exp);
    check_count++;
    if ($isunknown(got) || int'(got) > exp + 1 || int'(got) + 1 < exp) begin
      err_total++;
      $display("ERROR %0t: count %h expected about %0d", $time, got, exp);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb_xfer(input logic [7:0] a, input logic wr, input logic [7:0] d);
    int k;
    logic [31:0] r;
    k = 0;
    r = $urandom();
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {r[31:8], d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      err_total++;
      $display("ERROR %0t: no ready", $time);
    end
    rd_d = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb_xfer(a, 1'b1, d);
  endtask

  // read and compare data and error flag
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic eerr);
    apb_xfer(a, 1'b0, 8'h00);
    chk(rd_d, {24'h000000, exp});
    chk({31'h0, rd_e}, {31'h0, eerr});
  endtask

  // watchdog: the wide timeout alone takes about 66k cycles
  initial begin
    repeat (95000) @(posedge pclk);
    err_total++;
    $display("ERROR %0t: watchdog expired", $time);
    end_sim();
  end

  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, demod_in_a, demod_in_b} = '0;
    {narrow_port_value, wide_port_value, combined_port_value} = 3'h0;
    void'($urandom(32'hE449));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // reset values of every register
    for (int i = 0; i < 12; i++) begin
      rd_chk({2'b00, i[3:0], 2'b00}, (i == 3) ? 8'hFF : 8'h00, 1'b0);
    end
    // read/write registers keep what was written
    v = 8'($urandom());
    wr(A_COMMON, v);
    rd_chk(A_COMMON, v, 1'b0);
    v = 8'($urandom());
    wr(A_HOLD, v);
    rd_chk(A_HOLD, v, 1'b0);
    v = 8'($urandom()) & 8'h5F;
    wr(A_WIDE, v);
    rd_chk(A_WIDE, v, 1'b0);
    wr(A_COMMON, 8'h00);
    wr(A_WIDE, 8'h00);
    // capture registers ignore writes
    for (int i = 8; i < 12; i++) begin
      wr({2'b00, i[3:0], 2'b00}, 8'($urandom()));
      rd_chk({2'b00, i[3:0], 2'b00}, 8'h00, 1'b0);
    end
    // unmapped and unaligned places
    wr(8'h30, 8'hFF);
    rd_chk(8'h30, 8'h00, 1'b1);
    rd_chk(8'h05, 8'h00, 1'b1);
    // pins follow the port values while routed to the port
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom());
      {narrow_port_value, wide_port_value, combined_port_value} <= v[2:0];
      repeat (4) @(posedge pclk);
      chk({29'h0, narrow_output_pin, wide_output_pin, combined_output_pin}, {29'h0, v[2:0]});
    end
    // counter outputs routed, counters idle: pins low despite port values high
    wr(A_NARROW, 8'h01);
    wr(A_WIDE, 8'h01);
    wr(A_COMMON, 8'h40);
    {narrow_port_value, wide_port_value, combined_port_value} <= 3'h7;
    repeat (4) @(posedge pclk);
    chk({29'h0, narrow_output_pin, wide_output_pin, combined_output_pin}, 32'h0);
    wr(A_NARROW, 8'h00);
    wr(A_WIDE, 8'h00);
    // demodulation: both edges, wide ignores edges
    wr(A_MASK, 8'h0F);
    wr(A_COMMON, 8'hA0);
    wr(A_WIDE, 8'h40);
    wr(A_NARROW, 8'h80);
    h_len = $urandom_range(200, 20);
    l_len = $urandom_range(200, 20);
    demod_in_a <= 1'b1;
    repeat (h_len) @(posedge pclk);
    demod_in_a <= 1'b0;
    repeat (l_len) @(posedge pclk);
    demod_in_a <= 1'b1;
    repeat (6) @(posedge pclk);
    apb_xfer({2'b00, dcc_pkg::IDX_NARROW_CAP_HI, 2'b00}, 1'b0, 8'h00);
    chk_near(rd_d[7:0], h_len);
    apb_xfer({2'b00, dcc_pkg::IDX_NARROW_CAP_LO, 2'b00}, 1'b0, 8'h00);
    chk_near(rd_d[7:0], l_len);
    apb_xfer(A_STAT, 1'b0, 8'h00);
    chk({31'h0, rd_d[dcc_pkg::IRQ_NCAP]}, 32'h1);
    chk({31'h0, rd_d[dcc_pkg::IRQ_WCAP]}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(A_WIDE, 8'h44);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    wr(A_NARROW, 8'h00);
    wr(A_STAT, 8'h0F);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    // wide counter recognises edges with the single bit clear
    hi = 8'($urandom());
    wr(A_HOLD, hi);
    wr({2'b00, dcc_pkg::IDX_WIDE_INIT_LO, 2'b00}, 8'h80);
    wr(A_WIDE, 8'h80);
    demod_in_a <= 1'b0;
    repeat (30) @(posedge pclk);
    demod_in_a <= 1'b1;
    repeat (6) @(posedge pclk);
    apb_xfer(A_STAT, 1'b0, 8'h00);
    chk({31'h0, rd_d[dcc_pkg::IRQ_WCAP]}, 32'h1);
    apb_xfer({2'b00, dcc_pkg::IDX_WIDE_CAP_HI, 2'b00}, 1'b0, 8'h00);
    chk(rd_d, {24'h000000, hi});
    apb_xfer({2'b00, dcc_pkg::IDX_WIDE_CAP_LO, 2'b00}, 1'b0, 8'h00);
    chk_near(rd_d[7:0], 128 - 29);
    // narrow timeout interrupt gated by the counter mask bit
    wr(A_WIDE, 8'h00);
    wr(A_STAT, 8'h0F);
    wr(A_NARROW, 8'h80);
    repeat (300) @(posedge pclk);
    apb_xfer(A_STAT, 1'b0, 8'h00);
    chk({31'h0, rd_d[dcc_pkg::IRQ_NTMO]}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(A_WIDE, 8'h02);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    wr(A_NARROW, 8'h00);
    wr(A_STAT, 8'h0F);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    // wide timeout flag: write 0 keeps it, write 1 clears it
    wr(A_WIDE, 8'h80);
    n = 0;
    do begin
      apb_xfer(A_WIDE, 1'b0, 8'h00);
      n++;
    end while (rd_d[dcc_pkg::WC_TIMEOUT] !== 1'b1 && n < 25000);
    chk({31'h0, rd_d[dcc_pkg::WC_TIMEOUT]}, 32'h1);
    wr(A_WIDE, 8'h00);
    rd_chk(A_WIDE, 8'h20, 1'b0);
    wr(A_WIDE, 8'h20);
    rd_chk(A_WIDE, 8'h00, 1'b0);
    end_sim();
  end
endmodule
